// [include/msd_map.svh]
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH
// ****************************************
// Address map
// ****************************************
`define MSD_IPTR_W      12
`define MSD_DATA_W      8
`define MSD_STK_DEPTH   6
`define MSD_WIN_LO      8'h40
`define MSD_WIN_HI      8'h7F
`define MSD_PTR_FIRST   8'h80
`define MSD_PTR_SECOND  8'h81
`define MSD_SD_FIRST    8'h82
`define MSD_SD_SECOND   8'h83
`define MSD_RAM_LO      8'h84
`define MSD_RAM_HI      8'hBF
`define MSD_RAM_WORDS   60
`define MSD_WIN_REG     8'hC9
`define MSD_ACC         8'hFF
`define MSD_USR_LO      12'h080
`define MSD_USR_HI      12'hF9F
`define MSD_UNDEF_RD    8'h00
`endif

// [include/msd_pkg.sv]
package msd_pkg;
  typedef enum logic [1:0] {
    MSD_SEL_NONE,
    MSD_SEL_WIN,
    MSD_SEL_RAM,
    MSD_SEL_REG
  } msd_sel_t;
  typedef enum logic [1:0] {
    MSD_STK_IDLE,
    MSD_STK_PUSH,
    MSD_STK_POP
  } msd_stk_op_t;
endpackage

// [include/msd_stk_if.sv]
`timescale 1ns/1ns
interface msd_stk_if;
  logic [11:0] push_addr;
  logic        push;
  logic        pop;
  logic [11:0] top_addr;
  logic [2:0]  level;
  logic        full;
  logic        empty;
  modport core  (output push_addr, output push, output pop,
                 input top_addr, input level, input full, input empty);
  modport stack (input push_addr, input push, input pop,
                 output top_addr, output level, output full, output empty);
endinterface

// [rtl/msd_stack.sv]
`timescale 1ns/1ns
`include "msd_map.svh"
module msd_stack (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  msd_stk_if.stack  stk
);
  // ****************************************
  // Six-entry return stack
  // ****************************************
  logic [`MSD_IPTR_W-1:0] stk_ff   [`MSD_STK_DEPTH];
  logic [`MSD_IPTR_W-1:0] nxt_stk  [`MSD_STK_DEPTH];
  logic [2:0]             level_ff;
  logic [2:0]             nxt_level;
  msd_pkg::msd_stk_op_t   op;

  always_comb begin
    if (stk.push) begin
      op = msd_pkg::MSD_STK_PUSH;
    end else if (stk.pop && level_ff != 3'h0) begin
      op = msd_pkg::MSD_STK_POP;
    end else begin
      op = msd_pkg::MSD_STK_IDLE;
    end
  end

  // Push shifts down, oldest entry drops when full
  genvar g;
  generate
    for (g = 0; g < `MSD_STK_DEPTH; g++) begin : g_ent
      always_comb begin
        case (op)
          msd_pkg::MSD_STK_PUSH: begin
            nxt_stk[g] = (g == 0) ? stk.push_addr : stk_ff[(g == 0) ? 0 : g-1];
          end
          msd_pkg::MSD_STK_POP: begin
            nxt_stk[g] = (g == `MSD_STK_DEPTH-1) ? stk_ff[g]
                       : stk_ff[(g == `MSD_STK_DEPTH-1) ? g : g+1];
          end
          default: begin
            nxt_stk[g] = stk_ff[g];
          end
        endcase
      end
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          stk_ff[g] <= 12'h000;
        end else begin
          stk_ff[g] <= nxt_stk[g];
        end
      end
    end
  endgenerate

  always_comb begin
    case (op)
      msd_pkg::MSD_STK_PUSH: begin
        nxt_level = (level_ff == 3'(`MSD_STK_DEPTH)) ? level_ff
                  : 3'(level_ff + 3'h1);
      end
      msd_pkg::MSD_STK_POP: begin
        nxt_level = 3'(level_ff - 3'h1);
      end
      default: begin
        nxt_level = level_ff;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_ff <= 3'h0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign stk.top_addr = stk_ff[0];
  assign stk.level    = level_ff;
  assign stk.full     = (level_ff == 3'(`MSD_STK_DEPTH));
  assign stk.empty    = (level_ff == 3'h0);
endmodule

// [rtl/msd_decoder.sv]
`timescale 1ns/1ns
`include "msd_map.svh"
module msd_decoder (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [11:0] i_instruction_pointer,
  input  wire logic        i_fetch,
  output logic      [7:0]  o_fetch_data,
  output logic             o_fetch_user_area,
  input  wire logic [7:0]  i_data_addr,
  input  wire logic        i_data_rd,
  input  wire logic        i_data_wr,
  input  wire logic [7:0]  i_data_wdata,
  output logic      [7:0]  o_data_rdata,
  input  wire logic [7:0]  i_acc_value,
  output logic             o_acc_wr,
  output logic      [7:0]  o_acc_wdata,
  input  wire logic        i_stk_push,
  input  wire logic        i_stk_pop,
  input  wire logic [11:0] i_stk_push_addr,
  output logic      [11:0] o_stk_top_addr,
  output logic      [2:0]  o_stk_level,
  output logic             o_stk_full,
  output logic             o_stk_empty,
  output logic      [11:0] o_rom_addr,
  input  wire logic [7:0]  i_rom_data,
  input  wire logic        i_protect_option,
  input  wire logic        i_protect_fuse,
  input  wire logic        i_ext_rd,
  input  wire logic [11:0] i_ext_addr,
  output logic      [7:0]  o_ext_rdata,
  output logic             o_ext_refused
);
  // ****************************************
  // Address decode
  // ****************************************
  function automatic msd_pkg::msd_sel_t dec_sel(input logic [7:0] a);
    if (a >= `MSD_WIN_LO && a <= `MSD_WIN_HI) begin
      dec_sel = msd_pkg::MSD_SEL_WIN;
    end else if (a >= `MSD_RAM_LO && a <= `MSD_RAM_HI) begin
      dec_sel = msd_pkg::MSD_SEL_RAM;
    end else if (a == `MSD_PTR_FIRST || a == `MSD_PTR_SECOND ||
                 a == `MSD_SD_FIRST || a == `MSD_SD_SECOND ||
                 a == `MSD_WIN_REG || a == `MSD_ACC) begin
      dec_sel = msd_pkg::MSD_SEL_REG;
    end else begin
      dec_sel = msd_pkg::MSD_SEL_NONE;
    end
  endfunction

  msd_pkg::msd_sel_t sel;
  logic              protected_rom;
  logic              win_hit;
  logic              ext_hit;
  logic [11:0]       win_rom_addr;
  logic [5:0]        ram_idx;

  assign sel           = dec_sel(i_data_addr);
  assign protected_rom = i_protect_option & i_protect_fuse;
  assign win_hit       = i_data_rd && (sel == msd_pkg::MSD_SEL_WIN);
  // Readout yields to a window read, ROM has one port
  assign ext_hit       = i_ext_rd && !protected_rom && !win_hit;
  assign ram_idx       = 6'(i_data_addr - `MSD_RAM_LO);

  // ****************************************
  // Core and window registers
  // ****************************************
  logic [7:0]  ptr_first_ff,  nxt_ptr_first;
  logic [7:0]  ptr_second_ff, nxt_ptr_second;
  logic [7:0]  sd_first_ff,   nxt_sd_first;
  logic [7:0]  sd_second_ff,  nxt_sd_second;
  logic [6:0]  win_base_ff,   nxt_win_base;
  logic [7:0]  ram_ff [`MSD_RAM_WORDS];
  logic        wr_reg;

  assign wr_reg = i_data_wr && (sel == msd_pkg::MSD_SEL_REG);

  always_comb begin
    nxt_ptr_first  = ptr_first_ff;
    nxt_ptr_second = ptr_second_ff;
    nxt_sd_first   = sd_first_ff;
    nxt_sd_second  = sd_second_ff;
    nxt_win_base   = win_base_ff;
    if (wr_reg) begin
      case (i_data_addr)
        `MSD_PTR_FIRST: begin
          nxt_ptr_first = i_data_wdata;
        end
        `MSD_PTR_SECOND: begin
          nxt_ptr_second = i_data_wdata;
        end
        `MSD_SD_FIRST: begin
          nxt_sd_first = i_data_wdata;
        end
        `MSD_SD_SECOND: begin
          nxt_sd_second = i_data_wdata;
        end
        `MSD_WIN_REG: begin
          nxt_win_base = i_data_wdata[6:0];
        end
        default: begin
          nxt_win_base = win_base_ff;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_first_ff  <= 8'h00;
      ptr_second_ff <= 8'h00;
      sd_first_ff   <= 8'h00;
      sd_second_ff  <= 8'h00;
    end else begin
      ptr_first_ff  <= nxt_ptr_first;
      ptr_second_ff <= nxt_ptr_second;
      sd_first_ff   <= nxt_sd_first;
      sd_second_ff  <= nxt_sd_second;
    end
  end

  // Window base keeps its value through reset
  always_ff @(posedge i_sys_clk) begin
    win_base_ff <= nxt_win_base;
  end

  // RAM array, no reset
  always_ff @(posedge i_sys_clk) begin
    if (i_data_wr && sel == msd_pkg::MSD_SEL_RAM) begin
      ram_ff[ram_idx] <= i_data_wdata;
    end
  end

  // ****************************************
  // ROM port and read mux
  // ****************************************
  assign win_rom_addr = 12'({win_base_ff, i_data_addr[5:0]});

  always_comb begin
    if (win_hit) begin
      o_rom_addr = win_rom_addr;
    end else if (ext_hit) begin
      o_rom_addr = i_ext_addr;
    end else begin
      o_rom_addr = i_instruction_pointer;
    end
  end

  logic [7:0] nxt_rdata, rdata_ff;
  logic [7:0] nxt_fetch, fetch_ff;
  logic [7:0] nxt_ext, ext_ff;
  logic       nxt_refused, refused_ff;
  logic       nxt_user, user_ff;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_data_rd) begin
      case (sel)
        msd_pkg::MSD_SEL_WIN: begin
          nxt_rdata = i_rom_data;
        end
        msd_pkg::MSD_SEL_RAM: begin
          nxt_rdata = ram_ff[ram_idx];
        end
        msd_pkg::MSD_SEL_REG: begin
          case (i_data_addr)
            `MSD_PTR_FIRST:  nxt_rdata = ptr_first_ff;
            `MSD_PTR_SECOND: nxt_rdata = ptr_second_ff;
            `MSD_SD_FIRST:   nxt_rdata = sd_first_ff;
            `MSD_SD_SECOND:  nxt_rdata = sd_second_ff;
            `MSD_ACC:        nxt_rdata = i_acc_value;
            default:         nxt_rdata = `MSD_UNDEF_RD;
          endcase
        end
        default: begin
          nxt_rdata = `MSD_UNDEF_RD;
        end
      endcase
    end
  end

  always_comb begin
    nxt_fetch = fetch_ff;
    nxt_user  = user_ff;
    if (i_fetch && !win_hit && !ext_hit) begin
      nxt_fetch = i_rom_data;
      nxt_user  = (i_instruction_pointer >= `MSD_USR_LO) &&
                  (i_instruction_pointer <= `MSD_USR_HI);
    end
  end

  always_comb begin
    nxt_ext     = ext_ff;
    nxt_refused = refused_ff;
    if (i_ext_rd) begin
      nxt_refused = protected_rom;
      nxt_ext     = ext_hit ? i_rom_data : `MSD_UNDEF_RD;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff   <= 8'h00;
      fetch_ff   <= 8'h00;
      user_ff    <= 1'b0;
      ext_ff     <= 8'h00;
      refused_ff <= 1'b0;
    end else begin
      rdata_ff   <= nxt_rdata;
      fetch_ff   <= nxt_fetch;
      user_ff    <= nxt_user;
      ext_ff     <= nxt_ext;
      refused_ff <= nxt_refused;
    end
  end

  assign o_data_rdata      = rdata_ff;
  assign o_fetch_data      = fetch_ff;
  assign o_fetch_user_area = user_ff;
  assign o_ext_rdata       = ext_ff;
  assign o_ext_refused     = refused_ff;
  assign o_acc_wr          = wr_reg && (i_data_addr == `MSD_ACC);
  assign o_acc_wdata       = i_data_wdata;

  // ****************************************
  // Return stack
  // ****************************************
  msd_stk_if stk ();
  assign stk.push      = i_stk_push;
  assign stk.pop       = i_stk_pop;
  assign stk.push_addr = i_stk_push_addr;

  msd_stack u_stack (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .stk       (stk.stack)
  );

  assign o_stk_top_addr = stk.top_addr;
  assign o_stk_level    = stk.level;
  assign o_stk_full     = stk.full;
  assign o_stk_empty    = stk.empty;
endmodule

// [sim/msd_rom_model.sv]
`timescale 1ns/1ns
// ****************************************
// Program store answering in the same cycle
// ****************************************
module msd_rom_model (
  input  wire logic [11:0] i_rom_addr,
  output logic      [7:0]  o_rom_data
);
  // Byte pattern: low address byte XOR the upper nibble repeated in both halves
  assign o_rom_data = i_rom_addr[7:0] ^ {i_rom_addr[11:8], i_rom_addr[11:8]};
endmodule

// [sim/msd_decoder_properties.sv]
`timescale 1ns/1ns
// ****************************************
// Port checks
// ****************************************
module msd_decoder_properties (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [11:0] i_instruction_pointer,
  input wire logic        i_fetch,
  input wire logic [7:0]  o_fetch_data,
  input wire logic        o_fetch_user_area,
  input wire logic [7:0]  i_data_addr,
  input wire logic        i_data_rd,
  input wire logic        i_data_wr,
  input wire logic [7:0]  i_data_wdata,
  input wire logic [7:0]  o_data_rdata,
  input wire logic [7:0]  i_acc_value,
  input wire logic        o_acc_wr,
  input wire logic [7:0]  o_acc_wdata,
  input wire logic        i_stk_push,
  input wire logic [2:0]  o_stk_level,
  input wire logic        o_stk_full,
  input wire logic [11:0] o_rom_addr,
  input wire logic [7:0]  i_rom_data,
  input wire logic        i_protect_option,
  input wire logic        i_protect_fuse,
  input wire logic        i_ext_rd,
  input wire logic [11:0] i_ext_addr,
  input wire logic [7:0]  o_ext_rdata,
  input wire logic        o_ext_refused
);
  logic win_rd;
  logic ext_ok;
  logic fetch_ok;
  assign win_rd = i_data_rd && i_data_addr[7:6] == 2'h1;
  assign ext_ok = i_ext_rd && !win_rd &&
                  !(i_protect_option && i_protect_fuse);
  assign fetch_ok = i_fetch && !win_rd && !ext_ok;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  win_addr_a: assert property (
    win_rd |-> o_rom_addr[5:0] == i_data_addr[5:0])
    else $error("window address low bits wrong");
  win_data_a: assert property (
    win_rd |=> o_data_rdata == $past(i_rom_data))
    else $error("window read data wrong");
  fetch_addr_a: assert property (
    fetch_ok |-> o_rom_addr == i_instruction_pointer)
    else $error("fetch address wrong");
  fetch_data_a: assert property (
    fetch_ok |=> o_fetch_data == $past(i_rom_data))
    else $error("fetch data wrong");
  user_area_a: assert property (
    fetch_ok |=> o_fetch_user_area ==
      ($past(i_instruction_pointer) inside {[12'h080:12'hf9f]}))
    else $error("user area flag wrong");
  acc_read_a: assert property (
    i_data_rd && i_data_addr == 8'hff |=> o_data_rdata == $past(i_acc_value))
    else $error("accumulator read wrong");
  acc_write_a: assert property (
    i_data_wr && i_data_addr == 8'hff |->
      o_acc_wr && o_acc_wdata == i_data_wdata)
    else $error("accumulator write wrong");
  base_read_a: assert property (
    i_data_rd && i_data_addr == 8'hc9 |=> o_data_rdata == 8'h00)
    else $error("window base readable");
  ext_refuse_a: assert property (
    i_ext_rd |=> o_ext_refused == $past(i_protect_option && i_protect_fuse))
    else $error("readout protection wrong");
  ext_blank_a: assert property (
    i_ext_rd && i_protect_option && i_protect_fuse |=> o_ext_rdata == 8'h00)
    else $error("protected readout returned data");
  ext_addr_a: assert property (
    ext_ok |-> o_rom_addr == i_ext_addr)
    else $error("readout address wrong");
  ext_data_a: assert property (
    ext_ok |=> o_ext_rdata == $past(i_rom_data))
    else $error("readout data wrong");
  stack_depth_a: assert property (
    i_stk_push |=> o_stk_level ==
      ($past(o_stk_full) ? 3'h6 : $past(o_stk_level) + 3'h1))
    else $error("stack depth wrong");
endmodule
bind msd_decoder msd_decoder_properties u_props (.i_sys_clk, .i_rst_n,
  .i_instruction_pointer, .i_fetch, .o_fetch_data, .o_fetch_user_area,
  .i_data_addr, .i_data_rd, .i_data_wr, .i_data_wdata, .o_data_rdata,
  .i_acc_value, .o_acc_wr, .o_acc_wdata, .i_stk_push, .o_stk_level,
  .o_stk_full, .o_rom_addr, .i_rom_data, .i_protect_option,
  .i_protect_fuse, .i_ext_rd, .i_ext_addr, .o_ext_rdata, .o_ext_refused);

// [sim/msd_decoder_tb.sv]
`timescale 1ns/1ns
// ****************************************
// Decoder bench
// ****************************************
module msd_decoder_tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [11:0] i_instruction_pointer = 12'h000, i_stk_push_addr = 12'h000;
  logic [11:0] i_ext_addr = 12'h000, o_rom_addr, o_stk_top_addr;
  logic [7:0]  i_data_addr = 8'h00, i_data_wdata = 8'h00;
  logic [7:0]  i_acc_value = 8'h3c, i_rom_data, o_fetch_data;
  logic [7:0]  o_data_rdata, o_acc_wdata, o_ext_rdata;
  logic        i_fetch = 1'b0, i_data_rd = 1'b0, i_data_wr = 1'b0;
  logic        i_stk_push = 1'b0, i_stk_pop = 1'b0, i_ext_rd = 1'b0;
  logic        i_protect_option = 1'b0, i_protect_fuse = 1'b0;
  logic        o_fetch_user_area, o_acc_wr, o_stk_full, o_stk_empty;
  logic        o_ext_refused;
  logic [2:0]  o_stk_level;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  msd_decoder DUT (.i_sys_clk, .i_rst_n, .i_instruction_pointer, .i_fetch,
    .o_fetch_data, .o_fetch_user_area, .i_data_addr, .i_data_rd, .i_data_wr,
    .i_data_wdata, .o_data_rdata, .i_acc_value, .o_acc_wr, .o_acc_wdata,
    .i_stk_push, .i_stk_pop, .i_stk_push_addr, .o_stk_top_addr, .o_stk_level,
    .o_stk_full, .o_stk_empty, .o_rom_addr, .i_rom_data, .i_protect_option,
    .i_protect_fuse, .i_ext_rd, .i_ext_addr, .o_ext_rdata, .o_ext_refused);
  msd_rom_model rom (.i_rom_addr(o_rom_addr), .o_rom_data(i_rom_data));
  function automatic logic [7:0] rom_val(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_data_addr <= a;
    i_data_wdata <= d;
    i_data_wr <= 1'b1;
    #1;
    chk(o_acc_wr, a == 8'hff);
    @(posedge i_sys_clk);
    i_data_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_data_addr <= a;
    i_data_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_data_rd <= 1'b0;
    #1;
    chk(o_data_rdata, exp);
  endtask
  task automatic fc(input logic [11:0] ip, input logic user);
    @(posedge i_sys_clk);
    i_instruction_pointer <= ip;
    i_fetch <= 1'b1;
    @(posedge i_sys_clk);
    i_fetch <= 1'b0;
    #1;
    chk(o_fetch_data, rom_val(ip));
    chk(o_fetch_user_area, user);
  endtask
  task automatic sk(input logic push, input logic pop, input logic [11:0] a);
    @(posedge i_sys_clk);
    i_stk_push <= push;
    i_stk_pop <= pop;
    i_stk_push_addr <= a;
    @(posedge i_sys_clk);
    i_stk_push <= 1'b0;
    i_stk_pop <= 1'b0;
    #1;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    wr(8'hc9, 8'h28);
    rdc(8'h59, rom_val(12'ha19));
    rdc(8'hc9, 8'h00);
    wr(8'h7f, 8'h55);
    rdc(8'h7f, rom_val(12'ha3f));
    wr(8'hc9, 8'h00);
    rdc(8'h40, rom_val(12'h000));
    for (int i = 0; i < 64; i++) wr(8'(8'h80 + i), 8'(8'ha0 ^ i));
    for (int i = 0; i < 64; i++) rdc(8'(8'h80 + i), 8'(8'ha0 ^ i));
    rdc(8'h00, 8'h00);
    rdc(8'hc3, 8'h00);
    wr(8'hff, 8'h5a);
    rdc(8'hff, 8'h3c);
    fc(12'h07f, 1'b0);
    fc(12'h080, 1'b1);
    fc(12'hf9f, 1'b1);
    fc(12'hfa0, 1'b0);
    chk(o_stk_empty, 1'b1);
    for (int i = 1; i < 8; i++) begin
      sk(1'b1, 1'b0, 12'(i));
      chk(o_stk_top_addr, 12'(i));
    end
    chk(o_stk_full, 1'b1);
    for (int i = 7; i > 1; i--) begin
      chk(o_stk_top_addr, 12'(i));
      sk(1'b0, 1'b1, 12'h000);
    end
    chk(o_stk_level, 3'h0);
    sk(1'b0, 1'b1, 12'h000);
    chk(o_stk_empty, 1'b1);
    sk(1'b1, 1'b1, 12'h0ab);
    chk(o_stk_top_addr, 12'h0ab);
    chk(o_stk_level, 3'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_sys_clk);
      i_protect_option <= i[0];
      i_protect_fuse <= i[1];
      i_ext_addr <= 12'(12'h5a0 + i);
      i_ext_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_ext_rd <= 1'b0;
      #1;
      chk(o_ext_refused, i == 3);
      chk(o_ext_rdata, (i == 3) ? 8'h00 : rom_val(12'(12'h5a0 + i)));
    end
    finish_test();
  end
endmodule
